// ===== verilog/irqp_pkg.sv
// shared constants, register map and carrier types of the priority block
package irqp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int IRQP_NSRC   = 30;
    localparam int IRQP_NDBG   = 3;
    localparam int IRQP_RW     = 16;
    localparam int IRQP_IDXW   = 5;
    localparam int IRQP_NREG   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_CFG_1  = 5'h01;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_CFG_2  = 5'h02;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_CFG_3  = 5'h03;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_CFG_4  = 5'h04;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_CFG_5  = 5'h05;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_ACT_LO = 5'h06;
    localparam logic [IRQP_IDXW-1:0] IRQP_IDX_ACT_HI = 5'h07;
    localparam int                   IRQP_IDX_LSB    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // writable bits per configuration register, reserved bits zero
    localparam logic [IRQP_RW-1:0] IRQP_MASK_CFG_1 = 16'h003f;
    localparam logic [IRQP_RW-1:0] IRQP_MASK_CFG_2 = 16'hffcf;
    localparam logic [IRQP_RW-1:0] IRQP_MASK_CFG_3 = 16'hfffc;
    localparam logic [IRQP_RW-1:0] IRQP_MASK_CFG_4 = 16'hfc3f;
    localparam logic [IRQP_RW-1:0] IRQP_MASK_CFG_5 = 16'hff3f;
    localparam logic [IRQP_RW-1:0] IRQP_CFG_RESET  = 16'h0000;
    localparam logic [1:0]         IRQP_CODE_OFF   = 2'h0;
    localparam logic [1:0]         IRQP_CODE_STEP  = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // per source: holding register and low bit of its two-bit field
    localparam int IRQP_SRC_REG [IRQP_NSRC] = '{
        1, 1, 1,
        2, 2, 2, 2, 2, 2, 2,
        3, 3, 3, 3, 3, 3, 3,
        4, 4, 4, 4, 4, 4,
        5, 5, 5, 5, 5, 5, 5};
    localparam int IRQP_SRC_LSB [IRQP_NSRC] = '{
        4, 2, 0,
        14, 12, 10, 8, 6, 2, 0,
        14, 12, 10, 8, 6, 4, 2,
        14, 12, 10, 4, 2, 0,
        14, 12, 10, 8, 4, 2, 0};

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic       valid;
        logic [1:0] level;
    } irqp_req_t;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [IRQP_IDXW-1:0] idx;
        logic [IRQP_RW-1:0]   wdata;
    } irqp_reg_cmd_t;

    typedef enum logic [1:0] {
        IRQP_BUS_IDLE = 2'b01,
        IRQP_BUS_WAIT = 2'b10
    } irqp_bus_state_t;

endpackage

// ===== verilog/irqp_level_decode.sv
// maps one two-bit priority field and its request onto an arbitration request
`timescale 1ns/10ps
`default_nettype none
module irqp_level_decode
    import irqp_pkg::*;
#(
    parameter bit DEBUG_SRC = 1'b0
) (
    input  wire logic [1:0] code,
    input  wire logic       req,
    output irqp_req_t       out
);

    always_comb begin
        out.valid = req && (code != IRQP_CODE_OFF);
        if (DEBUG_SRC) begin
            out.level = code;
        end else begin
            out.level = code - IRQP_CODE_STEP;
        end
    end

endmodule
`default_nettype wire

// ===== verilog/irqp_ahb_slave.sv
// ahb-lite slave front end with one wait state, registered answer
`timescale 1ns/10ps
`default_nettype none
module irqp_ahb_slave
    import irqp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    output irqp_reg_cmd_t             cmd,
    input  wire logic [IRQP_RW-1:0]   rdata
);

    irqp_bus_state_t      state;
    logic                 pend_write;
    logic                 pend_mapped;
    logic [IRQP_IDXW-1:0] pend_idx;
    logic                 accept;
    logic                 hit;

    // only word-aligned addresses inside the block window are mapped
    assign hit    = (haddr[31:IRQP_IDX_LSB+IRQP_IDXW] == '0) && (haddr[1:0] == 2'h0)
                    && (haddr[IRQP_IDX_LSB +: IRQP_IDXW] < IRQP_IDXW'(IRQP_NREG));
    assign accept = hsel && htrans[1] && hready && (state == IRQP_BUS_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state       <= IRQP_BUS_IDLE;
            pend_write  <= 1'b0;
            pend_mapped <= 1'b0;
            pend_idx    <= '0;
        end else begin
            unique case (state)
                IRQP_BUS_IDLE: begin
                    if (accept) begin
                        state       <= IRQP_BUS_WAIT;
                        pend_write  <= hwrite;
                        pend_mapped <= hit;
                        pend_idx    <= haddr[IRQP_IDX_LSB +: IRQP_IDXW];
                    end
                end
                IRQP_BUS_WAIT: begin
                    state <= IRQP_BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hrdata    <= '0;
        end else begin
            hreadyout <= !accept;
            if (state == IRQP_BUS_WAIT) begin
                hrdata <= {16'h0000, (pend_mapped && !pend_write) ? rdata : 16'h0000};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_comb begin
        cmd.wr    = (state == IRQP_BUS_WAIT) && pend_write && pend_mapped;
        cmd.rd    = (state == IRQP_BUS_WAIT) && !pend_write && pend_mapped;
        cmd.idx   = pend_idx;
        cmd.wdata = hwdata[IRQP_RW-1:0];
    end

endmodule
`default_nettype wire

// ===== verilog/irqp_priority_regs.sv
// interrupt priority configuration registers and per-source level decode
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module irqp_priority_regs
    import irqp_pkg::*;
#(
    parameter int NSRC = IRQP_NSRC
) (
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    input  wire logic [NSRC-1:0] src_req,
    output irqp_req_t            arb_req [NSRC]
);

    ////////////////////////////////////////////////////////////////////////////
    // bus front end
    irqp_reg_cmd_t      cmd;
    logic [IRQP_RW-1:0] rd_value;

    irqp_ahb_slave u_bus (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .cmd       (cmd),
        .rdata     (rd_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writable bits of each configuration register
    function automatic logic [IRQP_RW-1:0] cfg_mask(input logic [IRQP_IDXW-1:0] idx);
        unique case (idx)
            IRQP_IDX_CFG_1: cfg_mask = IRQP_MASK_CFG_1;
            IRQP_IDX_CFG_2: cfg_mask = IRQP_MASK_CFG_2;
            IRQP_IDX_CFG_3: cfg_mask = IRQP_MASK_CFG_3;
            IRQP_IDX_CFG_4: cfg_mask = IRQP_MASK_CFG_4;
            IRQP_IDX_CFG_5: cfg_mask = IRQP_MASK_CFG_5;
            default:        cfg_mask = 16'h0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // configuration storage, indexed by register index
    logic [IRQP_RW-1:0] cfg [IRQP_IDX_CFG_1:IRQP_IDX_CFG_5];

    genvar r;
    generate
        for (r = IRQP_IDX_CFG_1; r <= IRQP_IDX_CFG_5; r++) begin : g_cfg
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    cfg[r] <= IRQP_CFG_RESET;
                end else if (cmd.wr && (cmd.idx == IRQP_IDXW'(r))) begin
                    cfg[r] <= cmd.wdata & cfg_mask(IRQP_IDXW'(r));
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // per-source decode
    irqp_req_t        dec [NSRC];
    logic [NSRC-1:0]  active;

    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : g_src
            irqp_level_decode #(
                .DEBUG_SRC (s < IRQP_NDBG)
            ) u_dec (
                .code (cfg[IRQP_SRC_REG[s]][IRQP_SRC_LSB[s] +: 2]),
                .req  (src_req[s]),
                .out  (dec[s])
            );

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    arb_req[s] <= '0;
                    active[s]  <= 1'b0;
                end else begin
                    arb_req[s] <= dec[s];
                    active[s]  <= dec[s].valid;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path: configuration registers and live request view
    logic [31:0] active_w;

    assign active_w = 32'(active);

    // only a read data phase selects a value, anything else returns zero
    always_comb begin
        rd_value = 16'h0000;
        if (cmd.rd) begin
            unique case (cmd.idx)
                IRQP_IDX_CFG_1,
                IRQP_IDX_CFG_2,
                IRQP_IDX_CFG_3,
                IRQP_IDX_CFG_4,
                IRQP_IDX_CFG_5:  rd_value = cfg[cmd.idx] & cfg_mask(cmd.idx);
                IRQP_IDX_ACT_LO: rd_value = active_w[IRQP_RW-1:0];
                IRQP_IDX_ACT_HI: rd_value = active_w[2*IRQP_RW-1:IRQP_RW];
                default:         rd_value = 16'h0000;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== dv/irqp_priority_regs_assertions.sv
// port assertions of the priority block
`timescale 1ns/10ps
`default_nettype none
module irqp_priority_regs_assertions
    import irqp_pkg::*;
#(
    parameter int NSRC = IRQP_NSRC
) (
    input wire logic            mclk,
    input wire logic            sys_rst,
    input wire logic            hsel,
    input wire logic [1:0]      htrans,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire logic [31:0]     hrdata,
    input wire logic [NSRC-1:0] src_req,
    input wire irqp_req_t       arb_req [NSRC]
);
    ////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_rst_clear;
        $fell(sys_rst) |-> hreadyout && !arb_req[0].valid && !arb_req[3].valid && hrdata == 0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("state not cleared");
    property p_wait;
        hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_upper;
        hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_dbg_lvl;
        arb_req[0].valid |-> arb_req[0].level != 2'h0;
    endproperty
    a_dbg_lvl: assert property (p_dbg_lvl) else $error("debug level zero");
    property p_oth_lvl;
        arb_req[3].valid |-> arb_req[3].level != 2'h3;
    endproperty
    a_oth_lvl: assert property (p_oth_lvl) else $error("level three reached");
    property p_noreq;
        !src_req[3] |=> !arb_req[3].valid;
    endproperty
    a_noreq: assert property (p_noreq) else $error("request without cause");
    property p_cause;
        arb_req[29].valid |-> $past(src_req[29]);
    endproperty
    a_cause: assert property (p_cause) else $error("valid without request");
    property p_rd_hold;
        hreadyout && $past(hreadyout) && !$fell(sys_rst) |-> $stable(hrdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind irqp_priority_regs irqp_priority_regs_assertions #(.NSRC(NSRC)) chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_req(src_req),
    .arb_req(arb_req));
`default_nettype wire

// ===== dv/irqp_src_model.sv
// peripheral request sources at the far side of the block
`timescale 1ns/10ps
`default_nettype none
module irqp_src_model
    import irqp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic [IRQP_NSRC-1:0] want,
    output logic      [IRQP_NSRC-1:0] src_req
);
    ////////////////////////////////////////
    // request lines change just after the edge, like a peripheral flop
    always_ff @(posedge mclk) begin
        src_req <= want;
    end
endmodule
`default_nettype wire

// ===== dv/irq_priority_level_regs_tb.sv
// self-checking bench of the priority block
`timescale 1ns/10ps
`default_nettype none
module irq_priority_level_regs_tb;
    import irqp_pkg::*;
    logic                 mclk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]          haddr, hwdata, hrdata, rd;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [IRQP_NSRC-1:0] want, src_req;
    irqp_req_t            arb_req [IRQP_NSRC];
    int                   fail_count, checks;
    logic [15:0]          masks [5] = '{IRQP_MASK_CFG_1, IRQP_MASK_CFG_2, IRQP_MASK_CFG_3,
                                        IRQP_MASK_CFG_4, IRQP_MASK_CFG_5};

    irqp_priority_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_req(src_req),
        .arb_req(arb_req));
    irqp_src_model src_u (.mclk(mclk), .want(want), .src_req(src_req));

    ////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                stop_test();
            end
            @(posedge mclk);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {25'h0, idx, 2'h0};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic set_all(input logic [15:0] v);
        for (int r = 1; r <= 5; r++) bus(1'b1, 5'(r), {16'h0, v});
        repeat (3) @(posedge mclk);
    endtask

    ////////////////////////////////////////
    // reset values, reserved bits and the register-less index 0
    task automatic t_regs;
        foreach (masks[i]) begin
            bus(1'b0, 5'(i + 1), 32'h0);
            chk(rd, 32'h0);
            bus(1'b1, 5'(i + 1), 32'hffffffff);
            bus(1'b0, 5'(i + 1), 32'h0);
            chk(rd, {16'h0, masks[i]});
        end
        bus(1'b1, 5'h00, 32'hffffffff);
        bus(1'b0, 5'h00, 32'h0);
        chk(rd, 32'h0);
    endtask
    // each field reaches only its own source
    task automatic t_fields;
        want <= '1;
        set_all(16'h0);
        for (int s = 0; s < IRQP_NSRC; s++) begin
            bus(1'b1, 5'(IRQP_SRC_REG[s]), 32'h3 << IRQP_SRC_LSB[s]);
            repeat (2) @(posedge mclk);
            for (int t = 0; t < IRQP_NSRC; t++)
                chk(32'(arb_req[t].valid), 32'(t == s));
            bus(1'b1, 5'(IRQP_SRC_REG[s]), 32'h0);
        end
    endtask
    // every code on every source, then requests withdrawn except on sources 0 and 29
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            set_all({8{2'(c)}});
            for (int s = 0; s < IRQP_NSRC; s++) begin
                chk(32'(arb_req[s].valid), 32'(c != 0));
                if (c != 0 && s < IRQP_NDBG) chk(32'(arb_req[s].level), 32'(c));
                else if (c != 0) chk(32'(arb_req[s].level), 32'(c - 1));
            end
        end
        want <= 30'h20000001;
        repeat (3) @(posedge mclk);
        for (int s = 0; s < IRQP_NSRC; s++)
            chk(32'(arb_req[s].valid), 32'(s == 0 || s == 29));
        // code 11 on a peripheral source is level 2, the fast-eligible level
        chk(32'(arb_req[29].level), 32'h2);
        // live request view, read only
        bus(1'b0, IRQP_IDX_ACT_LO, 32'h0);
        chk(rd, 32'h00000001);
        bus(1'b0, IRQP_IDX_ACT_HI, 32'h0);
        chk(rd, 32'h00002000);
        bus(1'b1, IRQP_IDX_ACT_LO, 32'hffffffff);
        bus(1'b0, IRQP_IDX_ACT_LO, 32'h0);
        chk(rd, 32'h00000001);
    endtask
    // reset in mid-run clears every field while requests stay raised
    task automatic t_reset;
        sys_rst <= 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        for (int s = 0; s < IRQP_NSRC; s++)
            chk(32'(arb_req[s].valid), 32'h0);
        foreach (masks[i]) begin
            bus(1'b0, 5'(i + 1), 32'h0);
            chk(rd, 32'h0);
        end
    endtask

    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        sys_rst = 1'b1;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        want    = '0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_fields();
        t_codes();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
